// ===== lsd_defs.svh
// Constants of the line state detector: register map, field positions,
// reset values and setting ranges.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH

// ==========================================================
// Register byte offsets
`define LSD_OFS_CTRL 8'h00
`define LSD_OFS_VOLT_THR 8'h04
`define LSD_OFS_CURR_THR 8'h08
`define LSD_OFS_VOLT_RATED 8'h0C
`define LSD_OFS_CURR_RATED 8'h10
`define LSD_OFS_STATUS 8'h14
`define LSD_OFS_INT_STAT 8'h18
`define LSD_OFS_INT_MASK 8'h1C

// ==========================================================
// Field positions
`define LSD_CTRL_OPER_BIT 0
`define LSD_ST_VOLT_LSB 0
`define LSD_ST_CURR_LSB 3
`define LSD_ST_DEAD_BIT 6
`define LSD_ST_LIVE_BIT 7
`define LSD_ST_BLOCK_BIT 8
`define LSD_INT_DEAD_SET 0
`define LSD_INT_DEAD_CLR 1
`define LSD_INT_LIVE_SET 2
`define LSD_INT_LIVE_CLR 3

// ==========================================================
// Reset values and ranges
`define LSD_RST_OPER 1'b0
`define LSD_RST_VOLT_THR 7'h3C
`define LSD_RST_CURR_THR 7'h0A
`define LSD_VOLT_THR_MIN 7'h0A
`define LSD_CURR_THR_MIN 7'h02
`define LSD_THR_MAX 7'h64
`define LSD_PCT_SCALE 7'h64
`define LSD_RST_RATED 16'h1000
`define LSD_RST_INT_MASK 4'h0

// ==========================================================
// Bus responses
`define LSD_RESP_OKAY 2'h0
`define LSD_RESP_SLVERR 2'h2

`endif

// ===== lsd_pkg.sv
// Types shared by the line state detector.
// Includes no header; lsd_defs.svh is not used here.
package lsd_pkg;

  // ==========================================================
  // Per-phase flag triplet
  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } lsd_phase_s;

  // ==========================================================
  // Bus write sequencing
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } lsd_wr_e;

  typedef logic [3:0] lsd_irq_t;

endpackage

// ===== lsd_line_state_detector.sv
// Dead / live line state detector with AXI4-Lite register access.
// Assumes magnitudes, sample strobe and block input come from logic on
// core_clk, so none of them is resynchronised.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lsd_defs.svh"

module lsd_line_state_detector #(
  parameter int MAG_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Magnitudes from the front end
  input wire logic magValid,
  input wire logic [MAG_W-1:0] voltMagA,
  input wire logic [MAG_W-1:0] voltMagB,
  input wire logic [MAG_W-1:0] voltMagC,
  input wire logic [MAG_W-1:0] currMagA,
  input wire logic [MAG_W-1:0] currMagB,
  input wire logic [MAG_W-1:0] currMagC,
  // Configuration logic
  input wire logic blockIn,
  // Line state and interrupt outputs
  output logic voltStartA,
  output logic voltStartB,
  output logic voltStartC,
  output logic currStartA,
  output logic currStartB,
  output logic currStartC,
  output logic lineDeadOut,
  output logic lineLiveOut,
  output logic irq,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int PW = MAG_W + 7;

  // ==========================================================
  // Elaboration check
  if (MAG_W < 8 || MAG_W > 24) begin : gBadWidth
    $error("MAG_W must lie between 8 and 24");
  end

  // ==========================================================
  // Functions

  // Magnitude as percent of rated, scaled to avoid a divider
  function automatic logic [PW-1:0] scaleMag(input logic [MAG_W-1:0] mag);
    return PW'(mag) * PW'(`LSD_PCT_SCALE);
  endfunction

  function automatic logic [PW-1:0] scaleThr(input logic [6:0] pct, input logic [MAG_W-1:0] rated);
    return PW'(pct) * PW'(rated);
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Registers
  logic operReg;
  logic [6:0] voltThrReg;
  logic [6:0] currThrReg;
  logic [MAG_W-1:0] voltRatedReg;
  logic [MAG_W-1:0] currRatedReg;
  lsd_pkg::lsd_irq_t intStatReg;
  lsd_pkg::lsd_irq_t intMaskReg;
  lsd_pkg::lsd_phase_s voltStartReg;
  lsd_pkg::lsd_phase_s currStartReg;
  logic deadReg;
  logic liveReg;

  lsd_pkg::lsd_wr_e wrState;
  logic [7:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;

  // ==========================================================
  // Comparators
  logic [PW-1:0] voltLimit;
  logic [PW-1:0] currLimit;
  lsd_pkg::lsd_phase_s voltAbove;
  lsd_pkg::lsd_phase_s voltBelow;
  lsd_pkg::lsd_phase_s currAbove;
  lsd_pkg::lsd_phase_s currBelow;
  logic enabled;
  lsd_pkg::lsd_phase_s voltStartNext;
  lsd_pkg::lsd_phase_s currStartNext;
  logic deadNext;
  logic liveNext;

  assign voltLimit = scaleThr(voltThrReg, voltRatedReg);
  assign currLimit = scaleThr(currThrReg, currRatedReg);

  always_comb begin
    voltAbove.a = scaleMag(voltMagA) > voltLimit;
    voltAbove.b = scaleMag(voltMagB) > voltLimit;
    voltAbove.c = scaleMag(voltMagC) > voltLimit;
    voltBelow.a = scaleMag(voltMagA) < voltLimit;
    voltBelow.b = scaleMag(voltMagB) < voltLimit;
    voltBelow.c = scaleMag(voltMagC) < voltLimit;
    currAbove.a = scaleMag(currMagA) > currLimit;
    currAbove.b = scaleMag(currMagB) > currLimit;
    currAbove.c = scaleMag(currMagC) > currLimit;
    currBelow.a = scaleMag(currMagA) < currLimit;
    currBelow.b = scaleMag(currMagB) < currLimit;
    currBelow.c = scaleMag(currMagC) < currLimit;
  end

  // A magnitude equal to the limit is neither above nor below
  assign enabled = operReg && !blockIn;

  always_comb begin
    voltStartNext = voltStartReg;
    currStartNext = currStartReg;
    deadNext = deadReg;
    liveNext = liveReg;
    if (!enabled) begin
      voltStartNext = '0;
      currStartNext = '0;
      deadNext = 1'b0;
      liveNext = 1'b0;
    end else if (magValid) begin
      voltStartNext = voltAbove;
      currStartNext = currAbove;
      deadNext = (&voltBelow) && (&currBelow);
      liveNext = &voltAbove;
    end
  end

  // ==========================================================
  // Line state flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      voltStartReg <= '0;
      currStartReg <= '0;
      deadReg <= 1'b0;
      liveReg <= 1'b0;
    end else begin
      voltStartReg <= voltStartNext;
      currStartReg <= currStartNext;
      deadReg <= deadNext;
      liveReg <= liveNext;
    end
  end

  assign voltStartA = voltStartReg.a;
  assign voltStartB = voltStartReg.b;
  assign voltStartC = voltStartReg.c;
  assign currStartA = currStartReg.a;
  assign currStartB = currStartReg.b;
  assign currStartC = currStartReg.c;
  assign lineDeadOut = deadReg;
  assign lineLiveOut = liveReg;

  // ==========================================================
  // Write channel
  logic writeFire;
  logic [31:0] wMerged;
  logic wrHit;

  assign writeFire = (wrState == lsd_pkg::WR_COLLECT) && !s_axi_awready && !s_axi_wready;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrState <= lsd_pkg::WR_COLLECT;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LSD_RESP_OKAY;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
    end else begin
      case (wrState)
        lsd_pkg::WR_COLLECT: begin
          // Address and data may arrive in either order
          if (s_axi_awvalid && s_axi_awready) begin
            awAddrReg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (writeFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
            wrState <= lsd_pkg::WR_RESP;
          end
        end
        lsd_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wrState <= lsd_pkg::WR_COLLECT;
          end
        end
        default: begin
          wrState <= lsd_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  always_comb begin
    wrHit = 1'b0;
    wMerged = 32'h0000_0000;
    case ({awAddrReg[7:2], 2'b00})
      `LSD_OFS_CTRL: begin
        wrHit = 1'b1;
        wMerged = mergeStrb({31'h0, operReg}, wDataReg, wStrbReg);
      end
      `LSD_OFS_VOLT_THR: begin
        wrHit = 1'b1;
        wMerged = mergeStrb({25'h0, voltThrReg}, wDataReg, wStrbReg);
      end
      `LSD_OFS_CURR_THR: begin
        wrHit = 1'b1;
        wMerged = mergeStrb({25'h0, currThrReg}, wDataReg, wStrbReg);
      end
      `LSD_OFS_VOLT_RATED: begin
        wrHit = 1'b1;
        wMerged = mergeStrb(32'(voltRatedReg), wDataReg, wStrbReg);
      end
      `LSD_OFS_CURR_RATED: begin
        wrHit = 1'b1;
        wMerged = mergeStrb(32'(currRatedReg), wDataReg, wStrbReg);
      end
      `LSD_OFS_STATUS: begin
        wrHit = 1'b1;
      end
      `LSD_OFS_INT_STAT: begin
        wrHit = 1'b1;
        wMerged = mergeStrb(32'h0000_0000, wDataReg, wStrbReg);
      end
      `LSD_OFS_INT_MASK: begin
        wrHit = 1'b1;
        wMerged = mergeStrb({28'h0, intMaskReg}, wDataReg, wStrbReg);
      end
      default: begin
        wrHit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] wrAddr;
  assign wrAddr = {awAddrReg[7:2], 2'b00};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      operReg <= `LSD_RST_OPER;
      voltThrReg <= `LSD_RST_VOLT_THR;
      currThrReg <= `LSD_RST_CURR_THR;
      voltRatedReg <= MAG_W'(`LSD_RST_RATED);
      currRatedReg <= MAG_W'(`LSD_RST_RATED);
      intMaskReg <= `LSD_RST_INT_MASK;
    end else if (writeFire) begin
      if (wrAddr == `LSD_OFS_CTRL) begin
        operReg <= wMerged[`LSD_CTRL_OPER_BIT];
      end
      // Out-of-range settings keep the previous value, no clamping
      if (wrAddr == `LSD_OFS_VOLT_THR && wMerged[31:7] == 25'h0 &&
          wMerged[6:0] >= `LSD_VOLT_THR_MIN && wMerged[6:0] <= `LSD_THR_MAX) begin
        voltThrReg <= wMerged[6:0];
      end
      if (wrAddr == `LSD_OFS_CURR_THR && wMerged[31:7] == 25'h0 &&
          wMerged[6:0] >= `LSD_CURR_THR_MIN && wMerged[6:0] <= `LSD_THR_MAX) begin
        currThrReg <= wMerged[6:0];
      end
      if (wrAddr == `LSD_OFS_VOLT_RATED) begin
        voltRatedReg <= wMerged[MAG_W-1:0];
      end
      if (wrAddr == `LSD_OFS_CURR_RATED) begin
        currRatedReg <= wMerged[MAG_W-1:0];
      end
      if (wrAddr == `LSD_OFS_INT_MASK) begin
        intMaskReg <= wMerged[3:0];
      end
    end
  end

  // ==========================================================
  // Interrupt status, set wins over write-one-to-clear
  lsd_pkg::lsd_irq_t intSet;
  lsd_pkg::lsd_irq_t intClr;

  always_comb begin
    intSet = '0;
    intSet[`LSD_INT_DEAD_SET] = deadNext && !deadReg;
    intSet[`LSD_INT_DEAD_CLR] = !deadNext && deadReg;
    intSet[`LSD_INT_LIVE_SET] = liveNext && !liveReg;
    intSet[`LSD_INT_LIVE_CLR] = !liveNext && liveReg;
    intClr = (writeFire && wrAddr == `LSD_OFS_INT_STAT) ? wMerged[3:0] : 4'h0;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      intStatReg <= 4'h0;
      irq <= 1'b0;
    end else begin
      intStatReg <= (intStatReg & ~intClr) | intSet;
      irq <= |(((intStatReg & ~intClr) | intSet) & intMaskReg);
    end
  end

  // ==========================================================
  // Read channel
  logic [31:0] rdValue;
  logic rdHit;
  logic [31:0] statusWord;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`LSD_ST_VOLT_LSB +: 3] = voltStartReg;
    statusWord[`LSD_ST_CURR_LSB +: 3] = currStartReg;
    statusWord[`LSD_ST_DEAD_BIT] = deadReg;
    statusWord[`LSD_ST_LIVE_BIT] = liveReg;
    statusWord[`LSD_ST_BLOCK_BIT] = blockIn;
  end

  always_comb begin
    rdHit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `LSD_OFS_CTRL: rdValue = {31'h0, operReg};
      `LSD_OFS_VOLT_THR: rdValue = {25'h0, voltThrReg};
      `LSD_OFS_CURR_THR: rdValue = {25'h0, currThrReg};
      `LSD_OFS_VOLT_RATED: rdValue = 32'(voltRatedReg);
      `LSD_OFS_CURR_RATED: rdValue = 32'(currRatedReg);
      `LSD_OFS_STATUS: rdValue = statusWord;
      `LSD_OFS_INT_STAT: rdValue = {28'h0, intStatReg};
      `LSD_OFS_INT_MASK: rdValue = {28'h0, intMaskReg};
      default: begin
        rdHit = 1'b0;
        rdValue = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LSD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdValue;
      s_axi_rresp <= rdHit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ===== lsd_line_state_detector_sva.sv
// Checker of the line state outputs of the detector.
// Assumes binding to lsd_line_state_detector; sees only its ports.
`timescale 1ns/1ps
module lsd_line_state_detector_sva #(
  parameter int MAG_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Inputs watched, plus the write response valid
  input wire logic magValid,
  input wire logic [MAG_W-1:0] voltMagA,
  input wire logic [MAG_W-1:0] currMagA,
  input wire logic blockIn,
  input wire logic s_axi_bvalid,
  // Outputs watched
  input wire logic voltStartA,
  input wire logic voltStartB,
  input wire logic voltStartC,
  input wire logic currStartA,
  input wire logic currStartB,
  input wire logic currStartC,
  input wire logic lineDeadOut,
  input wire logic lineLiveOut
);
  logic [7:0] outs;
  assign outs = {lineLiveOut, lineDeadOut, currStartC, currStartB, currStartA, voltStartC, voltStartB, voltStartA};
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ========
  // Line state relations
  property p_dead; lineDeadOut |-> outs[5:0] == 6'h00; endproperty
  a_dead: assert property (p_dead) else $error("dead with a start flag");
  property p_live; lineLiveOut == (voltStartA && voltStartB && voltStartC); endproperty
  a_live: assert property (p_live) else $error("live differs from voltage flags");
  property p_blk; blockIn |=> outs == 8'h00; endproperty
  a_blk: assert property (p_blk) else $error("output while blocked");
  property p_off; blockIn [*2] |-> outs == 8'h00; endproperty
  a_off: assert property (p_off) else $error("output held while blocked");
  property p_vrise; $rose(voltStartA) |-> $past(magValid) && !$past(blockIn) && $past(voltMagA) != '0; endproperty
  a_vrise: assert property (p_vrise) else $error("voltage flag rose without cause");
  property p_crise; $rose(currStartA) |-> $past(magValid) && !$past(blockIn) && $past(currMagA) != '0; endproperty
  a_crise: assert property (p_crise) else $error("current flag rose without cause");
  // A write may switch operation off, so its cycle is exempt
  property p_hold; !magValid && !blockIn && !s_axi_bvalid |=> $stable(outs); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without a sample");
  property p_excl; !(lineDeadOut && lineLiveOut); endproperty
  a_excl: assert property (p_excl) else $error("dead and live together");
endmodule

bind lsd_line_state_detector lsd_line_state_detector_sva #(.MAG_W(MAG_W)) u_sva (
  .core_clk(core_clk), .reset(reset), .magValid(magValid), .voltMagA(voltMagA), .currMagA(currMagA),
  .blockIn(blockIn), .s_axi_bvalid(s_axi_bvalid), .voltStartA(voltStartA), .voltStartB(voltStartB),
  .voltStartC(voltStartC), .currStartA(currStartA), .currStartB(currStartB), .currStartC(currStartC),
  .lineDeadOut(lineDeadOut), .lineLiveOut(lineLiveOut));

// ===== lsd_front_end.sv
// Model of the magnitude front end and the configuration logic.
// Assumes the bench requests a sample with a one-cycle sendReq.
`timescale 1ns/1ps
module lsd_front_end #(
  parameter int MAG_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Requests from the bench
  input wire logic sendReq,
  input wire logic stall,
  input wire logic blkSet,
  input wire logic [5:0][MAG_W-1:0] sendMag,
  // Towards the detector
  output logic magValid,
  output logic [5:0][MAG_W-1:0] magOut,
  output logic blockIn
);
  logic pendReg;
  logic [5:0][MAG_W-1:0] holdReg;
  // ========
  // Strobe, late by one cycle for each stalled cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      magValid <= 1'b0;
      pendReg <= 1'b0;
      holdReg <= '0;
      blockIn <= 1'b0;
    end else begin
      magValid <= (sendReq || pendReg) && !stall;
      pendReg <= (sendReq || pendReg) && stall;
      blockIn <= blkSet;
      if (sendReq) begin
        holdReg <= sendMag;
      end
    end
  end
  // Inverse between strobes, so a stray capture shows
  assign magOut = magValid ? holdReg : ~holdReg;
endmodule

// ===== lsd_line_state_detector_tb.sv
// Self-checking bench of the line state detector.
// Assumes the front-end model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "lsd_defs.svh"
module lsd_line_state_detector_tb;
  localparam int MW = 16;
  localparam logic [31:0] TV [8] = '{32'h09, 32'h0A, 32'h65, 32'h64, 32'h01, 32'h02, 32'h80000014, 32'h64};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic sendReq = 1'b0;
  logic stall = 1'b0;
  logic blkSet = 1'b0;
  logic [5:0][MW-1:0] sendMag = '0;
  logic [5:0][MW-1:0] mag;
  logic magValid, blockIn, irq, oper;
  logic [7:0] outs;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] vThr = 7'h3C;
  logic [6:0] cThr = 7'h0A;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 76789;

  lsd_front_end #(.MAG_W(MW)) fe (.core_clk(core_clk), .reset(reset), .sendReq(sendReq), .stall(stall),
    .blkSet(blkSet), .sendMag(sendMag), .magValid(magValid), .magOut(mag), .blockIn(blockIn));
  lsd_line_state_detector #(.MAG_W(MW)) uut (.core_clk(core_clk), .reset(reset), .magValid(magValid),
    .voltMagA(mag[0]), .voltMagB(mag[1]), .voltMagC(mag[2]), .currMagA(mag[3]), .currMagB(mag[4]),
    .currMagC(mag[5]), .blockIn(blockIn), .voltStartA(outs[0]), .voltStartB(outs[1]), .voltStartC(outs[2]),
    .currStartA(outs[3]), .currStartB(outs[4]), .currStartC(outs[5]), .lineDeadOut(outs[6]),
    .lineLiveOut(outs[7]), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // ========
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic smp(input logic [5:0][MW-1:0] m, input logic b);
    sendMag <= m;
    blkSet <= b;
    sendReq <= 1'b1;
    stall <= 1'($random(seed));
    @(posedge core_clk);
    sendReq <= 1'b0;
    stall <= 1'b0;
    while (!magValid) @(posedge core_clk);
    // Outputs stand until the next strobe, so look one edge later
    @(posedge core_clk);
  endtask
  function automatic logic [31:0] expect_outs(input logic [5:0][MW-1:0] m, input logic b);
    logic [7:0] e;
    logic [5:0] lo;
    logic [31:0] lim;
    e = 8'h00;
    for (int k = 0; k < 6; k++) begin
      lim = ((k < 3) ? vThr : cThr) * 32'(`LSD_RST_RATED);
      e[k] = 32'(m[k]) * `LSD_PCT_SCALE > lim;
      lo[k] = 32'(m[k]) * `LSD_PCT_SCALE < lim;
    end
    e[6] = &lo;
    e[7] = &e[2:0];
    return (b || !oper) ? 32'h0 : 32'(e);
  endfunction
  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end

  // ========
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [5:0][MW-1:0] m;
    logic b;
    oper = 1'b0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rchk(`LSD_OFS_CTRL, 32'h0);
    rchk(`LSD_OFS_VOLT_THR, 32'h3C);
    rchk(`LSD_OFS_CURR_THR, 32'h0A);
    rchk(`LSD_OFS_VOLT_RATED, 32'(`LSD_RST_RATED));
    rchk(`LSD_OFS_CURR_RATED, 32'(`LSD_RST_RATED));
    smp({6{16'h1FFF}}, 1'b0);
    chk(32'(outs), 32'h0);
    wr(8'h20, 32'h1, r);
    chk(32'(r), 32'(`LSD_RESP_SLVERR));
    rd(8'h24, d, r);
    chk({d[29:0], r}, 32'(`LSD_RESP_SLVERR));
    for (int i = 0; i < 8; i++) begin
      wr((i < 4) ? `LSD_OFS_VOLT_THR : `LSD_OFS_CURR_THR, TV[i], r);
      if (TV[i] >= ((i < 4) ? 32'hA : 32'h2) && TV[i] <= 32'h64) begin
        if (i < 4) vThr = TV[i][6:0];
        else cThr = TV[i][6:0];
      end
      rchk((i < 4) ? `LSD_OFS_VOLT_THR : `LSD_OFS_CURR_THR, (i < 4) ? 32'(vThr) : 32'(cThr));
    end
    wr(`LSD_OFS_VOLT_THR, 32'h19, r);
    vThr = 7'h19;
    wr(`LSD_OFS_CURR_THR, 32'h0A, r);
    cThr = 7'h0A;
    wr(`LSD_OFS_CTRL, 32'h1, r);
    oper = 1'b1;
    // Equal, dead and live corners first, then random, live corner again last
    for (int i = 0; i < 45; i++) begin
      for (int k = 0; k < 6; k++) m[k] = 16'($random(seed)) & ((k < 3) ? 16'h07FF : 16'h03FF);
      b = ($random(seed) & 7) == 0;
      if (i < 3) b = 1'b0;
      if (i == 0) m = {{3{16'h0000}}, {3{16'h0400}}};
      if (i == 1) m = '0;
      if (i == 2 || i == 44) m = {{3{16'h03FF}}, {3{16'h0401}}};
      if (i == 44) b = 1'b0;
      smp(m, b);
      chk(32'(outs), expect_outs(m, b));
    end
    rchk(`LSD_OFS_STATUS, expect_outs(m, 1'b0));
    wr(`LSD_OFS_INT_STAT, 32'h0F, r);
    wr(`LSD_OFS_INT_MASK, 32'h01, r);
    chk(32'(irq), 32'h0);
    smp('0, 1'b0);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    rchk(`LSD_OFS_INT_STAT, 32'h09);
    wr(`LSD_OFS_INT_MASK, 32'h00, r);
    wr(`LSD_OFS_INT_STAT, 32'h01, r);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    rchk(`LSD_OFS_INT_STAT, 32'h08);
    smp({{3{16'h0000}}, {3{16'h0401}}}, 1'b0);
    wr(`LSD_OFS_CTRL, 32'h0, r);
    repeat (2) @(posedge core_clk);
    chk(32'(outs), 32'h0);
    report_and_stop;
  end
endmodule
